// ---- ddsl_pkg.sv ----
// Package with widths, preset codes and enumerations for the DAC load front end.
package ddsl_pkg;
  localparam int unsigned DATA_WIDTH = 12;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [11:0] PRESET_HALF = 12'h800;
  localparam logic [11:0] PRESET_ZERO = 12'h000;
  localparam logic [11:0] DAC_RESET_VALUE = 12'h000;
  localparam logic [11:0] SHIFT_RESET_VALUE = 12'h000;
  localparam logic [3:0] BIT_COUNT_RESET = 4'h0;

  typedef enum logic [1:0]
  {
    DDSL_RUN,
    DDSL_PRESET,
    DDSL_HOLD
  } ddsl_mode_type;
endpackage : ddsl_pkg

// ---- ddsl_pins_if.sv ----
// Interface carrying the synchronised host pin levels and the serial clock rise and load strobe fall edges.
`timescale 1ns/100ps
interface ddsl_pins_if;
  logic selectN;
  logic serialClk;
  logic serialData;
  logic loadAN;
  logic loadBN;
  logic presetN;
  logic presetHigh;
  logic powerDownN;
  logic clkRise;
  logic loadAFall;
  logic loadBFall;

  modport producer
  (
    output selectN, serialClk, serialData, loadAN, loadBN,
    output presetN, presetHigh, powerDownN, clkRise, loadAFall, loadBFall
  );
  modport consumer
  (
    input selectN, serialClk, serialData, loadAN, loadBN,
    input presetN, presetHigh, powerDownN, clkRise, loadAFall, loadBFall
  );
endinterface : ddsl_pins_if

// ---- ddsl_pin_sync.sv ----
// Two-flop synchronisers for the host pins plus edge detection on the clean side.
`timescale 1ns/100ps
module ddsl_pin_sync
(
  input  wire logic clk,             // System clock.
  input  wire logic sys_rst,         // Asynchronous reset, active high.
  input  wire logic [7:0] pinsRaw,   // Raw pins, see packing in top.
  ddsl_pins_if.producer pins         // Synchronised levels and edges.
);
  import ddsl_pkg::*;

  logic [7:0] meta_q;
  logic [7:0] sync_q;
  logic [7:0] prev_q;

  // Idle levels are high for every active-low pin so reset looks quiet.
  localparam logic [7:0] IDLE = 8'hBD;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= IDLE;
      sync_q <= IDLE;
    end
    else
    begin
      meta_q <= pinsRaw;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      prev_q <= IDLE;
    else
      prev_q <= sync_q;
  end

  assign pins.selectN    = sync_q[0];
  assign pins.serialClk  = sync_q[1];
  assign pins.serialData = sync_q[2];
  assign pins.loadAN     = sync_q[3];
  assign pins.loadBN     = sync_q[4];
  assign pins.presetN    = sync_q[5];
  assign pins.presetHigh = sync_q[6];
  assign pins.powerDownN = sync_q[7];
  assign pins.clkRise    = sync_q[1] & ~prev_q[1];
  assign pins.loadAFall  = ~sync_q[3] & prev_q[3];
  assign pins.loadBFall  = ~sync_q[4] & prev_q[4];
endmodule : ddsl_pin_sync

// ---- ddsl_dac_load.sv ----
// Serial shift register and dual DAC registers of the DAC load front end.
//
// Functional notes
// - Chip select high freezes shift register.
// - Chip select never gates the load strobes.
// - Each rising serial clock with chip select low shifts, MSB first.
// - Serial data enters shift register directly.
// - Load A low: DAC A follows shifter.
// - Load B low: DAC B follows shifter.
// - Reset low forces both DAC registers preset.
// - Preset level high gives 800, else 000.
// - Shutdown keeps all register contents.
// - Shifting and loads still work in shutdown.
// - After shutdown outputs use latest DAC values.
// - Word is 12 or 10 bits, MSB first.
// - Load falling edge updates, rising edge latches.
`timescale 1ns/100ps
module ddsl_dac_load
#(
  parameter int unsigned WIDTH = ddsl_pkg::DATA_WIDTH  // 12 or 10 bits.
)
(
  input  wire logic             clk,             // 250 MHz system clock.
  input  wire logic             sys_rst,         // Async reset, active high.
  input  wire logic             chip_select_n,   // Enables shifting when low.
  input  wire logic             serial_clk,      // Host serial clock pin.
  input  wire logic             serial_data_in,  // Host serial data pin.
  input  wire logic             load_strobe_a_n, // DAC A load, level low.
  input  wire logic             load_strobe_b_n, // DAC B load, level low.
  input  wire logic             preset_reset_n,  // DAC preset, active low.
  input  wire logic             preset_level,    // High selects half-scale.
  input  wire logic             power_down_n,    // Shutdown, active low.
  output logic [WIDTH-1:0]      dacAValue,       // DAC A register.
  output logic [WIDTH-1:0]      dacBValue,       // DAC B register.
  output logic [WIDTH-1:0]      shiftValue,      // Shift register contents.
  output logic                  shutdownActive,  // Analog shutdown request.
  output logic                  wordComplete     // Full word shifted in.
);
  import ddsl_pkg::*;

  // Only the two documented word widths have a defined preset code.
  if (WIDTH != 12 && WIDTH != 10)
  begin : g_bad_width
    $error("ddsl_dac_load: WIDTH must be 12 or 10");
  end

  ddsl_pins_if pins ();

  ddsl_pin_sync u_sync
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pinsRaw ({power_down_n, preset_level, preset_reset_n, load_strobe_b_n,
               load_strobe_a_n, serial_data_in, serial_clk, chip_select_n}),
    .pins    (pins)
  );

  // Preset code: top bit only, scaled to the word width.
  function automatic logic [WIDTH-1:0] presetCode(input logic high);
    logic [WIDTH-1:0] code;
    code = '0;
    if (high)
      code = PRESET_HALF[11 -: WIDTH];
    else
      code = PRESET_ZERO[11 -: WIDTH];
    return code;
  endfunction : presetCode

  ddsl_mode_type mode_d;
  logic [WIDTH-1:0] shift_q;
  logic [WIDTH-1:0] shift_d;
  logic [WIDTH-1:0] dacA_q;
  logic [WIDTH-1:0] dacB_q;
  logic [3:0]       bitCount_q;
  logic             shutdown_q;
  logic             shiftEn;

  always_comb
  begin
    if (!pins.presetN)
      mode_d = DDSL_PRESET;
    else if (pins.selectN)
      mode_d = DDSL_HOLD;
    else
      mode_d = DDSL_RUN;
  end

  // Shutdown does not gate shifting, since loads must work while asleep.
  assign shiftEn = !pins.selectN && pins.clkRise;
  // The newest bit enters at the LSB; old MSBs fall off the top.
  assign shift_d = {shift_q[WIDTH-2:0], pins.serialData};

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      shift_q <= SHIFT_RESET_VALUE[WIDTH-1:0];
    else if (shiftEn)
      shift_q <= shift_d;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bitCount_q <= BIT_COUNT_RESET;
    else if (pins.selectN)
      bitCount_q <= BIT_COUNT_RESET;
    else if (shiftEn && bitCount_q != 4'(WIDTH))
      bitCount_q <= bitCount_q + 4'h1;
  end

  // The load strobes ignore chip select altogether. A strobe held low
  // keeps its register transparent, tracking the shifter each cycle.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      dacA_q <= DAC_RESET_VALUE[WIDTH-1:0];
    else
    begin
      case (mode_d)
        DDSL_PRESET:
          dacA_q <= presetCode(pins.presetHigh);
        DDSL_RUN,
        DDSL_HOLD:
          if (!pins.loadAN || pins.loadAFall)
            dacA_q <= shift_q;
        default:
          dacA_q <= dacA_q;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      dacB_q <= DAC_RESET_VALUE[WIDTH-1:0];
    else
    begin
      case (mode_d)
        DDSL_PRESET:
          dacB_q <= presetCode(pins.presetHigh);
        DDSL_RUN,
        DDSL_HOLD:
          if (!pins.loadBN || pins.loadBFall)
            dacB_q <= shift_q;
        default:
          dacB_q <= dacB_q;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      shutdown_q <= 1'b0;
    else
      shutdown_q <= !pins.powerDownN;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wordComplete <= 1'b0;
    else
      wordComplete <= (bitCount_q == 4'(WIDTH));
  end

  // Outputs read the DAC registers straight, so leaving shutdown shows
  // whatever was loaded most recently, asleep or not.
  assign dacAValue      = dacA_q;
  assign dacBValue      = dacB_q;
  assign shiftValue     = shift_q;
  assign shutdownActive = shutdown_q;
endmodule : ddsl_dac_load

// ---- ddsl_dac_load_properties.sv ----
// Port assertions for the DAC load front end.
`timescale 1ns/100ps
module ddsl_dac_load_properties #(parameter int unsigned WIDTH = 12)
(
  input wire logic clk, sys_rst, chip_select_n, serial_clk, serial_data_in,
  input wire logic load_strobe_a_n, load_strobe_b_n, preset_reset_n,
  input wire logic preset_level, power_down_n, shutdownActive, wordComplete,
  input wire logic [WIDTH-1:0] dacAValue, dacBValue, shiftValue
);
  wire logic q = load_strobe_a_n & load_strobe_b_n & preset_reset_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pin-level count of accepted serial clock rises, saturating at a word.
  logic [4:0] riseCnt;
  logic       prevClk;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      riseCnt <= 5'h00;
      prevClk <= 1'h0;
    end
    else
    begin
      prevClk <= serial_clk;
      if (chip_select_n)
        riseCnt <= 5'h00;
      else if (serial_clk && !prevClk && riseCnt != 5'(WIDTH))
        riseCnt <= riseCnt + 5'h01;
    end
  end
  property p_wc; (riseCnt == 5'(WIDTH) && !chip_select_n)[*3] |=>
    wordComplete; endproperty
  a_wc: assert property (p_wc) else $error("word");
  property p_cs; chip_select_n[*4] |-> $stable(shiftValue); endproperty
  a_cs: assert property (p_cs) else $error("cs");
  property p_sh; $rose(serial_clk) && !chip_select_n |-> ##3 shiftValue ==
    {$past(shiftValue[WIDTH-2:0]), $past(serial_data_in, 3)}; endproperty
  a_sh: assert property (p_sh) else $error("shift");
  property p_la; (!load_strobe_a_n && preset_reset_n)[*4] |->
    dacAValue == shiftValue; endproperty
  a_la: assert property (p_la) else $error("load a");
  property p_lb; (!load_strobe_b_n && preset_reset_n)[*4] |->
    dacBValue == shiftValue; endproperty
  a_lb: assert property (p_lb) else $error("load b");
  property p_hd; q[*4] |=> $stable(dacAValue) && $stable(dacBValue);
  endproperty
  a_hd: assert property (p_hd) else $error("hold");
  property p_ps; !preset_reset_n[*4] |-> dacBValue == dacAValue &&
    dacAValue == (preset_level ? 1'h1 << (WIDTH-1) : 1'h0); endproperty
  a_ps: assert property (p_ps) else $error("preset");
  property p_pd; (q && chip_select_n)[*4] ##0 $fell(power_down_n) |=>
    ($stable(shiftValue) && $stable(dacAValue))[*3]; endproperty
  a_pd: assert property (p_pd) else $error("sleep");
  property p_sd; !power_down_n[*5] |-> shutdownActive; endproperty
  a_sd: assert property (p_sd) else $error("status");
endmodule : ddsl_dac_load_properties

// ---- ddsl_host_model.sv ----
// Host model driving the serial and strobe pins.
`timescale 1ns/100ps
module ddsl_host_model
(
  input wire logic clk,
  output logic chip_select_n = 1'h1, serial_clk = 1'h0,
  output logic serial_data_in = 1'h0,
  output logic load_strobe_a_n = 1'h1, load_strobe_b_n = 1'h1
);
  task automatic send(input logic [15:0] w, input int n, input logic cs);
    @(posedge clk);
    for (int i = n - 1; i >= 0; i--) // MSB first.
    begin
      chip_select_n <= cs;
      serial_data_in <= w[i];
      repeat (4) @(posedge clk);
      serial_clk <= 1'h1;
      repeat (4) @(posedge clk);
      serial_clk <= 1'h0;
    end
    serial_data_in <= ~w[0];
    chip_select_n <= 1'h1; // Whole word before a load.
    repeat (4) @(posedge clk);
  endtask : send
  // Strobes move only while the serial clock rests.
  task automatic load(input logic b, cs);
    @(posedge clk);
    chip_select_n <= cs;
    load_strobe_a_n <= b;
    load_strobe_b_n <= !b;
    repeat (6) @(posedge clk);
    {chip_select_n, load_strobe_a_n, load_strobe_b_n} <= 3'h7;
    repeat (6) @(posedge clk);
  endtask : load
endmodule : ddsl_host_model

// ---- ddsl_dac_load_tb.sv ----
// Self-checking bench of the DAC load front end.
`timescale 1ns/100ps
module ddsl_dac_load_tb;
  import ddsl_pkg::*;
  typedef struct packed {logic [15:0] w; logic [4:0] n; logic [2:0] f;
    logic [11:0] a, d;} ddsl_row_type;
  ddsl_row_type rows [5] = '{'{16'h0ABC, 5'h0C, 3'h1, 12'hABC, 12'h000},
    '{16'h05A3, 5'h0C, 3'h3, 12'hABC, 12'h5A3},
    '{16'h00F0, 5'h0C, 3'h5, 12'h5A3, 12'h5A3},
    '{16'h5123, 5'h10, 3'h2, 12'h5A3, 12'h123},
    '{16'h0FFF, 5'h0C, 3'h1, 12'hFFF, 12'h123}};
  logic clk = 1'h0, sys_rst = 1'h1, preset_reset_n = 1'h1;
  logic preset_level = 1'h0, power_down_n = 1'h1;
  wire logic chip_select_n, serial_clk, serial_data_in;
  wire logic load_strobe_a_n, load_strobe_b_n;
  logic [11:0] dacAValue, dacBValue, pv;
  int errCount = 0, nChecks = 0;
  initial forever #2 clk = ~clk;
  ddsl_dac_load u_ddsl_dac_load (.clk, .sys_rst, .chip_select_n,
    .serial_clk, .serial_data_in, .load_strobe_a_n, .load_strobe_b_n,
    .preset_reset_n, .preset_level, .power_down_n, .dacAValue, .dacBValue,
    .shiftValue(), .shutdownActive(), .wordComplete());
  ddsl_host_model u_ddsl_host_model (.clk, .chip_select_n, .serial_clk,
    .serial_data_in, .load_strobe_a_n, .load_strobe_b_n);
  task automatic check(input string t, input logic [11:0] seen, exp);
    #1;
    nChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", t, exp, seen);
    end
  endtask : check
  task automatic setp(input logic [2:0] v);
    @(posedge clk);
    {preset_reset_n, preset_level, power_down_n} <= v;
    repeat (6) @(posedge clk);
  endtask : setp
  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tallyAndFinish
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    check("reset dacA", dacAValue, DAC_RESET_VALUE);
    foreach (rows[i])
    begin
      u_ddsl_host_model.send(rows[i].w, rows[i].n, rows[i].f[2]);
      u_ddsl_host_model.load(rows[i].f[1], rows[i].f[0]);
      check("dacA", dacAValue, rows[i].a);
      check("dacB", dacBValue, rows[i].d);
    end
    $display("row tests done");
    setp(3'h6);
    u_ddsl_host_model.send(16'h0456, 12, 1'h0);
    u_ddsl_host_model.load(1'h1, 1'h1);
    setp(3'h7);
    check("wake dacA", dacAValue, 12'hFFF);
    check("wake dacB", dacBValue, 12'h456);
    $display("shutdown test done");
    for (int l = 1; l >= 0; l--)
    begin
      pv = l ? PRESET_HALF : PRESET_ZERO;
      setp({1'h0, l[0], 1'h1});
      check("preset dacB", dacBValue, pv);
      check("preset dacA", dacAValue, pv);
      setp({1'h1, l[0], 1'h1});
    end
    $display("preset test done");
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    check("rerun dacA", dacAValue, DAC_RESET_VALUE);
    check("rerun dacB", dacBValue, DAC_RESET_VALUE);
    u_ddsl_host_model.send(16'h0321, 12, 1'h0);
    u_ddsl_host_model.load(1'h0, 1'h1);
    check("rerun load", dacAValue, 12'h321);
    $display("reset test done");
    tallyAndFinish();
  end
endmodule : ddsl_dac_load_tb
bind ddsl_dac_load ddsl_dac_load_properties #(.WIDTH(WIDTH))
  u_ddsl_dac_load_properties (.clk, .sys_rst, .chip_select_n, .serial_clk,
  .serial_data_in, .load_strobe_a_n, .load_strobe_b_n, .preset_reset_n,
  .preset_level, .power_down_n, .shutdownActive, .wordComplete, .dacAValue,
  .dacBValue, .shiftValue);
